/* bench/cld_link_monitor.sv */
// assertions over the link that joins the host end to the device end
// assumes one clock domain, ref_clk, with rst asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
module cld_link_monitor
   import cld_pkg::*;
(
   input wire logic ref_clk, // common clock
   input wire logic rst, // reset, active high
   input wire logic [CLD_ADDR_W-1:0] regAddr, // link offset
   input wire logic [CLD_DATA_W-1:0] regWData, // link write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   input wire logic [CLD_DATA_W-1:0] regRData, // read data
   input wire logic txHalted, // halt level
   input wire logic dmaEndFlag, // end flag level
   input wire logic dmaRdReq, // dma read request
   input wire logic dmaWrReq // dma write request
);
   logic [2:0] shAct; // action field as last written on the link
   logic [3:0] shDma; // dma register as last written: ovs, zero, rd, wr
   logic collWr; // link write to the collision register
   logic resumeWr; // that write carries a resume code
   assign collWr = regWr && (regAddr == CLD_REG_COLL);
   assign resumeWr = collWr && (regWData[2:1] == 2'b01);
   // follow what the device should hold, so reads can be predicted
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shAct <= CLD_COLL_RST[2:0];
         shDma <= CLD_DMA_RST[3:0];
      end else begin
         if (collWr) shAct <= regWData[2:0];
         if (regWr && (regAddr == CLD_REG_DMA)) shDma <= {regWData[3], 1'b0, regWData[1:0]};
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   coll_read_a: assert property (regRd && regAddr == CLD_REG_COLL |=> regRData == {5'h00, $past(shAct)})
      else $error("collision register read back wrong");
   dma_read_a: assert property (regRd && regAddr == CLD_REG_DMA |=> regRData == {4'h0, $past(shDma)})
      else $error("dma register read back wrong");
   auto_no_halt_a: assert property (!txHalted && shAct[2] |=> !txHalted)
      else $error("halt raised in an automatic mode");
   halt_hold_a: assert property (txHalted && !resumeWr |=> txHalted)
      else $error("halt left without a resume code");
   halt_release_a: assert property (txHalted && resumeWr |=> !txHalted)
      else $error("resume code did not release the halt");
   rd_gate_a: assert property (!shDma[1] |=> !dmaRdReq)
      else $error("dma read request while reads disabled");
   wr_gate_a: assert property (!shDma[0] |=> !dmaWrReq)
      else $error("dma write request while writes disabled");
   end_clear_a: assert property ($fell(dmaEndFlag) |-> $past(regWr && regAddr == CLD_REG_DMA && regWData[1:0] == 2'b00))
      else $error("end flag dropped without a 00 enable write");
   both_en_block_a: assert property (regWr && regAddr == CLD_REG_DMA |-> regWData[1:0] != 2'b11)
      else $error("both dma enables sent together");
endmodule : cld_link_monitor
`default_nettype wire

/* bench/tb.sv */
// self-checking bench: host end and device end joined by one link
// assumes the package codes and the hand-over timing of both ends
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cld_pkg::*;
   logic ref_clk = 1'b0; // 25 MHz clock
   logic rst = 1'b1; // reset, active high
   logic pcCardMode = 1'b0; // card mode level
   logic [2:0] swAddr = 3'h0; // software offset
   logic [7:0] swWData = 8'h00; // software write data
   logic swWr = 1'b0; // software write strobe
   logic swRd = 1'b0; // software read strobe
   logic [7:0] swRData; // software read data
   logic irq; // level interrupt
   logic excessCollision = 1'b0; // sixteenth collision pulse
   logic rxLenValid = 1'b0; // frame length pulse
   logic [10:0] rxLen = 11'h000; // frame length
   logic bufRdReady = 1'b1; // buffer has data
   logic bufWrReady = 1'b1; // buffer has room
   logic dmaEndSet = 1'b0; // dma end pulse
   logic retryPkt, skipPkt, txHaltOut, rxDrop, dmaEndOut; // device user outputs
   logic rdLate = 1'b0; // a read answer stands this cycle
   logic [7:0] expQ[$]; // expected read data, oldest first
   int n_fail = 0; // mismatches
   int n_tests = 0; // comparisons
   cld_if link(); // the link between the two ends
   cld_host u_cld_host (.ref_clk(ref_clk), .rst(rst), .link(link), .pcCardMode(pcCardMode), .swAddr(swAddr),
      .swWData(swWData), .swWr(swWr), .swRd(swRd), .swRData(swRData), .irq(irq));
   cld_device u_cld_device (.ref_clk(ref_clk), .rst(rst), .link(link), .excessCollision(excessCollision),
      .rxLenValid(rxLenValid), .rxLen(rxLen), .bufRdReady(bufRdReady), .bufWrReady(bufWrReady),
      .dmaEndSet(dmaEndSet), .retryPkt(retryPkt), .skipPkt(skipPkt), .txHaltOut(txHaltOut),
      .rxDrop(rxDrop), .dmaEndOut(dmaEndOut));
   cld_link_monitor u_cld_link_monitor (.ref_clk(ref_clk), .rst(rst), .regAddr(link.regAddr),
      .regWData(link.regWData), .regWr(link.regWr), .regRd(link.regRd), .regRData(link.regRData),
      .txHalted(link.txHalted), .dmaEndFlag(link.dmaEndFlag), .dmaRdReq(link.dmaRdReq), .dmaWrReq(link.dmaWrReq));
   // free-running clock
   always #20 ref_clk = ~ref_clk;
   // verdict and end of run
   task automatic tally_and_finish();
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // compare a byte result
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte
   // compare a single output bit
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   // software write, one cycle strobe
   task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      swAddr <= a;
      swWData <= d;
      swWr <= 1'b1;
      @(posedge ref_clk);
      swWr <= 1'b0;
   endtask : sw_wr
   // software read; the answer is noted for the watcher
   task automatic sw_rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      swAddr <= a;
      swRd <= 1'b1;
      expQ.push_back(e);
      @(posedge ref_clk);
      swRd <= 1'b0;
   endtask : sw_rd
   // fetch a device register through the host peek path
   task automatic peek(input logic [3:0] r, input logic [7:0] e);
      sw_wr(CLD_SW_PEEK, {4'h0, r});
      repeat (3) @(posedge ref_clk);
      sw_rd(CLD_SW_PEEKDATA, e);
   endtask : peek
   // sixteenth collision, then the device reaction one cycle on
   task automatic collide(input logic eRetry, input logic eSkip, input logic eHalt);
      @(posedge ref_clk);
      excessCollision <= 1'b1;
      @(posedge ref_clk);
      excessCollision <= 1'b0;
      #1;
      chk_bit("retryPkt", eRetry, retryPkt);
      chk_bit("skipPkt", eSkip, skipPkt);
      chk_bit("txHaltOut", eHalt, txHaltOut);
   endtask : collide
   // resume code written while halted
   task automatic resume(input logic [2:0] c, input logic eRetry, input logic eSkip);
      sw_wr(CLD_SW_COLL, {5'h00, c});
      @(posedge ref_clk);
      #1;
      chk_bit("retryPkt", eRetry, retryPkt);
      chk_bit("skipPkt", eSkip, skipPkt);
      chk_bit("txHaltOut", 1'b0, txHaltOut);
   endtask : resume
   // received frame length and the drop decision
   task automatic rx(input logic [10:0] len, input logic ovs);
      @(posedge ref_clk);
      rxLen <= len;
      rxLenValid <= 1'b1;
      @(posedge ref_clk);
      rxLenValid <= 1'b0;
      #1;
      chk_bit("rxDrop", (len >= CLD_OVERSIZE_LEN) && !ovs, rxDrop);
   endtask : rx
   // watcher: marks the cycle in which a read answer stands
   always @(posedge ref_clk) rdLate <= swRd;
   // watcher: compares the standing answer with the oldest note
   always @(negedge ref_clk) begin
      if (rdLate === 1'b1) chk_byte("swRData", expQ.pop_front(), swRData);
   end
   // watchdog, far beyond the expected run
   initial begin
      #(40 * 6000);
      n_fail++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      void'($urandom(32'hf72e));
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      sw_rd(CLD_SW_COLL, CLD_COLL_RST);
      sw_rd(CLD_SW_LIVE, 8'h00);
      peek(CLD_REG_DMA, CLD_DMA_RST);
      sw_wr(CLD_SW_COLL, 8'hFE);
      #1;
      chk_byte("regWData", 8'h06, link.regWData);
      peek(CLD_REG_COLL, 8'h06);
      collide(1'b1, 1'b0, 1'b0);
      sw_wr(CLD_SW_COLL, {5'h00, CLD_ACT_AUTO_SKIP});
      collide(1'b0, 1'b1, 1'b0);
      sw_wr(CLD_SW_STAT, 8'h0F);
      sw_wr(CLD_SW_MASK, 8'h01);
      // manual codes 2 and 3; the resume must be repeated after every halt
      for (int m = 0; m < 2; m++) begin
         sw_wr(CLD_SW_COLL, {5'h00, 2'b01, m[0]});
         collide(1'b0, 1'b0, 1'b1);
         repeat (2) @(posedge ref_clk);
         #1;
         chk_bit("irq", 1'b1, irq);
         resume(CLD_RES_RETRY, 1'b1, 1'b0);
         collide(1'b0, 1'b0, 1'b1);
         resume(CLD_RES_SKIP, 1'b0, 1'b1);
         sw_wr(CLD_SW_STAT, 8'h01);
         repeat (2) @(posedge ref_clk);
         #1;
         chk_bit("irq", 1'b0, irq);
      end
      // masked halt: sticky status without interrupt
      sw_wr(CLD_SW_MASK, 8'h00);
      collide(1'b0, 1'b0, 1'b1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk_bit("irq", 1'b0, irq);
      sw_rd(CLD_SW_STAT, 8'h01);
      sw_rd(CLD_SW_LIVE, 8'h01);
      resume(CLD_RES_SKIP, 1'b0, 1'b1);
      sw_wr(CLD_SW_STAT, 8'h0F);
      // dma enables, reserved bits stripped
      sw_wr(CLD_SW_DMA, 8'hF6);
      peek(CLD_REG_DMA, 8'h02);
      sw_rd(CLD_SW_LIVE, 8'h04);
      // an empty receive buffer must hold the read request back
      bufRdReady <= 1'b0;
      sw_rd(CLD_SW_LIVE, 8'h00);
      bufRdReady <= 1'b1;
      sw_wr(CLD_SW_DMA, 8'h01);
      // the request follows the new enable one cycle after the link write lands
      @(posedge ref_clk);
      sw_rd(CLD_SW_LIVE, 8'h08);
      sw_wr(CLD_SW_DMA, 8'h03);
      sw_rd(CLD_SW_DMA, 8'h01);
      sw_rd(CLD_SW_STAT, 8'h0C);
      pcCardMode <= 1'b1;
      sw_wr(CLD_SW_DMA, 8'h02);
      sw_rd(CLD_SW_DMA, 8'h01);
      pcCardMode <= 1'b0;
      dmaEndSet <= 1'b1;
      @(posedge ref_clk);
      dmaEndSet <= 1'b0;
      sw_rd(CLD_SW_LIVE, 8'h0A);
      sw_wr(CLD_SW_DMA, 8'h08);
      // let the write request drop one cycle after the enables clear
      @(posedge ref_clk);
      sw_rd(CLD_SW_LIVE, 8'h00);
      #1;
      chk_bit("dmaEndOut", 1'b0, dmaEndOut);
      // end flag rise, refusals and the earlier peek are all sticky
      sw_rd(CLD_SW_STAT, 8'h0E);
      // long frames: removal off, then on; boundaries first, then random
      for (int o = 1; o >= 0; o--) begin
         sw_wr(CLD_SW_DMA, {4'h0, o[0], 3'h0});
         for (int i = 0; i < 10; i++) begin
            rx((i == 0) ? 11'h6FF : (i == 1) ? CLD_OVERSIZE_LEN : (i == 2) ? CLD_MAX_LEN
               : 11'h600 + 11'($urandom_range(511)), o[0]);
         end
      end
      repeat (2) @(posedge ref_clk);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire

/* hdl/cld_device.sv */
// register bank for excess collision handling and dma enables
// assumes transmitter, receiver and buffer logic on the user side,
// all synchronous to ref_clk; the host end drives the link strobes
`timescale 1ns/1ps
`default_nettype none
module cld_device
   import cld_pkg::*;
(
   input wire logic ref_clk, // 25 MHz clock
   input wire logic rst, // asynchronous reset, active high
   cld_if.dev link, // register link to the host end
   input wire logic excessCollision, // pulse: sixteenth collision on a packet
   input wire logic rxLenValid, // pulse: rxLen holds a finished frame length
   input wire logic [CLD_LEN_W-1:0] rxLen, // received frame length in bytes
   input wire logic bufRdReady, // receive buffer has data for a dma read
   input wire logic bufWrReady, // buffer has room for a dma write
   input wire logic dmaEndSet, // pulse: dma transfer reached its end
   output logic retryPkt, // pulse: retransmit the collided packet
   output logic skipPkt, // pulse: drop collided packet, send next
   output logic txHaltOut, // level: transmitter held after collisions
   output logic rxDrop, // pulse: reject the frame just received
   output logic dmaEndOut // level: dma end flag
);

   // collision handling states
   typedef enum logic [1:0] {
      COL_RUN = 2'b01, // transmitter running
      COL_HALT = 2'b10 // waiting for a resume code
   } cld_col_e;

   // whole state of the bank
   typedef struct packed {
      cld_col_e col; // collision state
      logic [CLD_ACT_W-1:0] act; // excess collision action field
      logic ovsDis; // oversize drop disable
      logic dmaRd; // dma read enable
      logic dmaWr; // dma write enable
      logic endFlag; // dma end flag
      logic [CLD_DATA_W-1:0] rdata; // read data to the link
      logic retry; // retransmit pulse
      logic skip; // skip pulse
      logic drop; // receive reject pulse
      logic rdReq; // dma read request
      logic wrReq; // dma write request
   } cld_dev_s;

   cld_dev_s s; // registered state
   cld_dev_s next_s; // next state
   logic wrColl; // write to the collision register
   logic wrDma; // write to the dma register
   logic [CLD_ACT_W-1:0] wrCode; // action code in the write data

   // decode of link writes
   always_comb begin
      wrColl = link.regWr && (link.regAddr == CLD_REG_COLL);
      wrDma = link.regWr && (link.regAddr == CLD_REG_DMA);
      wrCode = link.regWData[CLD_ACT_LSB +: CLD_ACT_W];
   end

   // next state of the whole bank
   always_comb begin
      next_s = s;
      // pulses last one cycle
      next_s.retry = 1'b0;
      next_s.skip = 1'b0;
      next_s.drop = 1'b0;
      // read data only stands in the cycle after a read
      next_s.rdata = '0;

      // collision register write keeps only the action field
      if (wrColl) begin
         next_s.act = wrCode;
      end

      // dma register write, reserved bits discarded
      if (wrDma) begin
         next_s.ovsDis = link.regWData[CLD_OVS_BIT];
         next_s.dmaRd = link.regWData[CLD_DMA_RD_BIT];
         next_s.dmaWr = link.regWData[CLD_DMA_WR_BIT];
      end

      // read answers, one cycle after the strobe
      if (link.regRd) begin
         case (link.regAddr)
            CLD_REG_COLL: begin
               next_s.rdata = {5'h00, s.act};
            end
            CLD_REG_DMA: begin
               // undefined top bits and bit 2 give zero
               next_s.rdata = {4'h0, s.ovsDis, 1'b0, s.dmaRd, s.dmaWr};
            end
            default: begin
               // unmapped offset reads zero
               next_s.rdata = '0;
            end
         endcase
      end

      // excess collision handling
      case (s.col)
         COL_RUN: begin
            if (excessCollision) begin
               if (s.act[2]) begin
                  if (s.act[0]) begin
                     next_s.skip = 1'b1;
                  end else begin
                     next_s.retry = 1'b1;
                  end
               end else begin
                  next_s.col = COL_HALT;
               end
            end
         end
         COL_HALT: begin
            if (wrColl && (wrCode == CLD_RES_RETRY)) begin
               next_s.retry = 1'b1;
               next_s.col = COL_RUN;
            end else if (wrColl && (wrCode == CLD_RES_SKIP)) begin
               next_s.skip = 1'b1;
               next_s.col = COL_RUN;
            end
         end
         default: begin
            // illegal code recovers to running
            next_s.col = COL_RUN;
         end
      endcase

      // long frame removal
      if (rxLenValid && !s.ovsDis && (rxLen >= CLD_OVERSIZE_LEN)) begin
         next_s.drop = 1'b1;
      end
      // with ovsDis set no frame is rejected here

      next_s.rdReq = s.dmaRd && bufRdReady;
      next_s.wrReq = s.dmaWr && bufWrReady;

      // dma end flag, a set in the clearing cycle wins
      if (wrDma && (link.regWData[CLD_DMA_RD_BIT:CLD_DMA_WR_BIT] == 2'h0)) begin
         next_s.endFlag = 1'b0;
      end
      if (dmaEndSet) begin
         next_s.endFlag = 1'b1;
      end
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s.col <= COL_RUN;
         s.act <= CLD_COLL_RST[CLD_ACT_LSB +: CLD_ACT_W];
         s.ovsDis <= CLD_DMA_RST[CLD_OVS_BIT];
         s.dmaRd <= CLD_DMA_RST[CLD_DMA_RD_BIT];
         s.dmaWr <= CLD_DMA_RST[CLD_DMA_WR_BIT];
         s.endFlag <= 1'b0;
         s.rdata <= '0;
         s.retry <= 1'b0;
         s.skip <= 1'b0;
         s.drop <= 1'b0;
         s.rdReq <= 1'b0;
         s.wrReq <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // link outputs straight from the state
   assign link.regRData = s.rdata;
   assign link.txHalted = (s.col == COL_HALT);
   assign link.dmaEndFlag = s.endFlag;
   assign link.dmaRdReq = s.rdReq;
   assign link.dmaWrReq = s.wrReq;

   // user side outputs straight from the state
   assign retryPkt = s.retry;
   assign skipPkt = s.skip;
   assign txHaltOut = (s.col == COL_HALT);
   assign rxDrop = s.drop;
   assign dmaEndOut = s.endFlag;

endmodule : cld_device
`default_nettype wire

/* hdl/cld_host.sv */
// host controller end: software orders in, device registers out
// assumes software on a plain strobe port, read data one cycle later,
// and the device end on the same ref_clk
`timescale 1ns/1ps
`default_nettype none
module cld_host
   import cld_pkg::*;
(
   input wire logic ref_clk, // 25 MHz clock
   input wire logic rst, // asynchronous reset, active high
   cld_if.host link, // register link to the device end
   input wire logic pcCardMode, // level: system runs in card mode
   input wire logic [CLD_SW_ADDR_W-1:0] swAddr, // software register offset
   input wire logic [CLD_DATA_W-1:0] swWData, // software write data
   input wire logic swWr, // one-cycle write strobe
   input wire logic swRd, // one-cycle read strobe
   output logic [CLD_DATA_W-1:0] swRData, // read data, cycle after swRd
   output logic irq // level interrupt
);

   // whole state of the controller
   typedef struct packed {
      logic [CLD_ADDR_W-1:0] busAddr; // link offset
      logic [CLD_DATA_W-1:0] busWData; // link write data
      logic busWr; // link write strobe
      logic busRd; // link read strobe
      logic [CLD_DATA_W-1:0] shColl; // copy of last collision write
      logic [CLD_DATA_W-1:0] shDma; // copy of last accepted dma write
      logic [CLD_ST_W-1:0] stat; // sticky events
      logic [CLD_ST_W-1:0] mask; // interrupt mask
      logic [CLD_DATA_W-1:0] rdata; // software read data
      logic irq; // interrupt
      logic haltPrev; // halt level last cycle
      logic endPrev; // end flag last cycle
      logic peekWait; // link read answer due now
      logic [CLD_DATA_W-1:0] peekData; // captured link read data
   } cld_host_s;

   cld_host_s s; // registered state
   cld_host_s next_s; // next state
   logic wrBoth; // both dma enables requested
   logic wrAny; // any dma enable requested

   // next state of the controller
   always_comb begin
      next_s = s;
      wrBoth = swWData[CLD_DMA_RD_BIT] && swWData[CLD_DMA_WR_BIT];
      wrAny = swWData[CLD_DMA_RD_BIT] || swWData[CLD_DMA_WR_BIT];
      // strobes and read data last one cycle
      next_s.busWr = 1'b0;
      next_s.busRd = 1'b0;
      next_s.rdata = '0;
      next_s.haltPrev = link.txHalted;
      next_s.endPrev = link.dmaEndFlag;
      next_s.peekWait = 1'b0;

      // software writes
      if (swWr) begin
         case (swAddr)
            CLD_SW_COLL: begin
               next_s.busAddr = CLD_REG_COLL;
               next_s.busWData = {5'h00, swWData[CLD_ACT_LSB +: CLD_ACT_W]};
               next_s.busWr = 1'b1;
               next_s.shColl = {5'h00, swWData[CLD_ACT_LSB +: CLD_ACT_W]};
            end
            CLD_SW_DMA: begin
               if (wrBoth || (pcCardMode && wrAny)) begin
                  next_s.stat[CLD_ST_REFUSED] = 1'b1;
               end else begin
                  next_s.busAddr = CLD_REG_DMA;
                  next_s.busWData = {4'h0, swWData[CLD_OVS_BIT], 1'b0,
                                     swWData[CLD_DMA_RD_BIT], swWData[CLD_DMA_WR_BIT]};
                  next_s.busWr = 1'b1;
                  next_s.shDma = {4'h0, swWData[CLD_OVS_BIT], 1'b0,
                                  swWData[CLD_DMA_RD_BIT], swWData[CLD_DMA_WR_BIT]};
               end
            end
            CLD_SW_STAT: begin
               // write one to clear
               next_s.stat = s.stat & ~swWData[CLD_ST_W-1:0];
            end
            CLD_SW_MASK: begin
               next_s.mask = swWData[CLD_ST_W-1:0];
            end
            CLD_SW_PEEK: begin
               // read a device register over the link
               next_s.busAddr = swWData[CLD_ADDR_W-1:0];
               next_s.busRd = 1'b1;
            end
            default: begin
               // other offsets ignore writes
               next_s.busWr = 1'b0;
            end
         endcase
      end

      // link read answer one cycle after the strobe
      if (s.busRd) begin
         next_s.peekWait = 1'b1;
      end
      if (s.peekWait) begin
         next_s.peekData = link.regRData;
         next_s.stat[CLD_ST_PEEK] = 1'b1;
      end

      // events set sticky bits, winning over a clear
      if (link.txHalted && !s.haltPrev) begin
         next_s.stat[CLD_ST_HALT] = 1'b1;
      end
      if (link.dmaEndFlag && !s.endPrev) begin
         next_s.stat[CLD_ST_DMAEND] = 1'b1;
      end

      // software reads
      if (swRd) begin
         case (swAddr)
            CLD_SW_COLL: next_s.rdata = s.shColl;
            CLD_SW_DMA: next_s.rdata = s.shDma;
            CLD_SW_STAT: next_s.rdata = {4'h0, s.stat};
            CLD_SW_MASK: next_s.rdata = {4'h0, s.mask};
            CLD_SW_LIVE: next_s.rdata = {4'h0, link.dmaWrReq, link.dmaRdReq,
                                         link.dmaEndFlag, link.txHalted};
            CLD_SW_PEEKDATA: next_s.rdata = s.peekData;
            default: next_s.rdata = '0;
         endcase
      end

      // interrupt follows the next status and mask
      next_s.irq = |(next_s.stat & next_s.mask);
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.stat <= CLD_ST_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state
   assign link.regAddr = s.busAddr;
   assign link.regWData = s.busWData;
   assign link.regWr = s.busWr;
   assign link.regRd = s.busRd;
   assign swRData = s.rdata;
   assign irq = s.irq;

endmodule : cld_host
`default_nettype wire

/* hdl/cld_if.sv */
// link between the register bank (device) and the host controller
// assumes one common clock, ref_clk, for both ends
`timescale 1ns/1ps
`default_nettype none
interface cld_if;
   import cld_pkg::*;
   logic [CLD_ADDR_W-1:0] regAddr; // register offset
   logic [CLD_DATA_W-1:0] regWData; // write data
   logic regWr; // one-cycle write strobe
   logic regRd; // one-cycle read strobe
   logic [CLD_DATA_W-1:0] regRData; // read data, cycle after regRd
   logic txHalted; // transmitter halted on excess collisions
   logic dmaEndFlag; // dma end flag
   logic dmaRdReq; // dma read request toward host
   logic dmaWrReq; // dma write request toward host

   // device end of the link
   modport dev (
      input regAddr, regWData, regWr, regRd,
      output regRData, txHalted, dmaEndFlag, dmaRdReq, dmaWrReq
   );
   // host end of the link
   modport host (
      output regAddr, regWData, regWr, regRd,
      input regRData, txHalted, dmaEndFlag, dmaRdReq, dmaWrReq
   );
endinterface : cld_if
`default_nettype wire

/* hdl/cld_pkg.sv */
// package of the collision limit and dma enable register bank
// holds register offsets, field positions, reset values, codes and lengths
// assumes both ends and the bench import it whole
package cld_pkg;

   // widths of the register link between the two ends
   localparam int CLD_ADDR_W = 4;
   localparam int CLD_DATA_W = 8;
   // received length width, enough for 2047 bytes
   localparam int CLD_LEN_W = 11;

   // device register offsets on the link
   localparam logic [3:0] CLD_REG_COLL = 4'hB;
   localparam logic [3:0] CLD_REG_DMA = 4'hC;

   // reset values of the two device registers
   localparam logic [7:0] CLD_COLL_RST = 8'h00;
   localparam logic [7:0] CLD_DMA_RST = 8'h00;

   // field positions
   localparam int CLD_ACT_LSB = 0;
   localparam int CLD_ACT_W = 3;
   localparam int CLD_DMA_WR_BIT = 0;
   localparam int CLD_DMA_RD_BIT = 1;
   localparam int CLD_DMA_ZERO_BIT = 2;
   localparam int CLD_OVS_BIT = 3;

   // excess collision action and resume codes
   localparam logic [2:0] CLD_ACT_AUTO_RETRY = 3'h6;
   localparam logic [2:0] CLD_ACT_AUTO_SKIP = 3'h7;
   localparam logic [2:0] CLD_RES_RETRY = 3'h2;
   localparam logic [2:0] CLD_RES_SKIP = 3'h3;

   // received length limits in bytes
   localparam logic [10:0] CLD_OVERSIZE_LEN = 11'h700;
   localparam logic [10:0] CLD_MAX_LEN = 11'h7FF;

   // software port offsets of the host end
   localparam int CLD_SW_ADDR_W = 3;
   localparam logic [2:0] CLD_SW_COLL = 3'h0;
   localparam logic [2:0] CLD_SW_DMA = 3'h1;
   localparam logic [2:0] CLD_SW_STAT = 3'h2;
   localparam logic [2:0] CLD_SW_MASK = 3'h3;
   localparam logic [2:0] CLD_SW_LIVE = 3'h4;
   localparam logic [2:0] CLD_SW_PEEK = 3'h5;
   localparam logic [2:0] CLD_SW_PEEKDATA = 3'h6;

   // host status and mask bit positions
   localparam int CLD_ST_W = 4;
   localparam int CLD_ST_HALT = 0;
   localparam int CLD_ST_DMAEND = 1;
   localparam int CLD_ST_REFUSED = 2;
   localparam int CLD_ST_PEEK = 3;
   localparam logic [3:0] CLD_ST_RST = 4'h0;

endpackage : cld_pkg
